//--- logic/cdt_map.vh
// Register offsets, field positions and reset values of the countdown timers
// Assumes word addressing within the timer register window
`ifndef CDT_MAP_VH
`define CDT_MAP_VH
// -----------------------------------------------------------------
// Window
// -----------------------------------------------------------------
`define CDT_WIN_BASE 22'h00_0C00
`define CDT_WIN_WORDS 7'h40
// -----------------------------------------------------------------
// Per timer block of 8 words: timer n at offset 8*n
// -----------------------------------------------------------------
`define CDT_TMR_STRIDE 6'h08
`define CDT_OFF_COUNT_LO 3'h0
`define CDT_OFF_COUNT_HI 3'h1
`define CDT_OFF_PERIOD_LO 3'h2
`define CDT_OFF_PERIOD_HI 3'h3
`define CDT_OFF_CTRL 3'h4
`define CDT_OFF_PRESCALE 3'h6
// -----------------------------------------------------------------
// Shared words
// -----------------------------------------------------------------
`define CDT_OFF_IRQ_STATUS 6'h30
`define CDT_OFF_IRQ_MASK 6'h31
`define CDT_OFF_CLK_SEL 6'h32
// -----------------------------------------------------------------
// Control fields
// -----------------------------------------------------------------
`define CDT_CTRL_STOP 4
`define CDT_CTRL_RELOAD 5
`define CDT_CTRL_ROUTE13 6
// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define CDT_RST_PERIOD 32'hFFFF_FFFF
`define CDT_RST_PRESCALE 16'h0000
`define CDT_RST_CTRL 16'h0000
`define CDT_RST_MASK 3'h0
`define CDT_CLK_SYSTEM 2'h0
`endif

//--- logic/cdt_tick_gen.v
// Selects timer clock source and turns it into one-cycle ticks
// Assumes source clocks are far slower than clock and already synchronised
`timescale 1ns/100ps
`include "cdt_map.vh"
module cdt_tick_gen (
  clock,
  rst_n,
  sel,
  src_osc_one,
  src_osc_two,
  src_ext,
  tick
);
  input clock;
  input rst_n;
  input [1:0] sel;
  input src_osc_one;
  input src_osc_two;
  input src_ext;
  output tick;
  wire clock;
  wire rst_n;
  wire [1:0] sel;
  wire src_osc_one;
  wire src_osc_two;
  wire src_ext;
  reg src_q;
  reg prev_q;
  wire src_d;
  // -----------------------------------------------------------------
  // Source mux
  // -----------------------------------------------------------------
  assign src_d = (sel == 2'h1) ? src_osc_one :
                 (sel == 2'h2) ? src_osc_two : src_ext;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      src_q <= src_d;
      prev_q <= src_q;
    end
  end
  // System clock output gives a tick every cycle
  assign tick = (sel == `CDT_CLK_SYSTEM) ? 1'b1 : (src_q & ~prev_q);
endmodule // cdt_tick_gen

//--- logic/cdt_timer.v
// One down counter with period, 16-bit prescaler and auto reload
// Assumes tick is a one-cycle enable in the clock domain
`timescale 1ns/100ps
`include "cdt_map.vh"
module cdt_timer #(
  parameter CW = 32,
  parameter PW = 16
) (
  clock,
  rst_n,
  tick,
  stop,
  reload_req,
  period,
  prescale,
  count,
  zero_evt
);
  input clock;
  input rst_n;
  input tick;
  input stop;
  input reload_req;
  input [CW-1:0] period;
  input [PW-1:0] prescale;
  output [CW-1:0] count;
  output zero_evt;
  wire clock;
  wire rst_n;
  wire tick;
  wire stop;
  wire reload_req;
  wire [CW-1:0] period;
  wire [PW-1:0] prescale;
  reg [CW-1:0] count_q;
  reg [PW-1:0] psc_q;
  wire step;
  wire at_zero;
  // -----------------------------------------------------------------
  // Prescaler and counter
  // -----------------------------------------------------------------
  // Prescale value n divides by n+1, so zero means no division
  assign step = tick & ~stop & (psc_q == {PW{1'b0}});
  assign at_zero = (count_q == {CW{1'b0}});
  assign zero_evt = step & at_zero;
  assign count = count_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= `CDT_RST_PERIOD;
      psc_q <= `CDT_RST_PRESCALE;
    end else if (reload_req) begin
      count_q <= period;
      psc_q <= prescale;
    end else if (tick & ~stop) begin
      if (psc_q == {PW{1'b0}}) begin
        psc_q <= prescale;
        if (at_zero) begin
          count_q <= period;
        end else begin
          count_q <= count_q - {{(CW-1){1'b0}}, 1'b1};
        end
      end else begin
        psc_q <= psc_q - {{(PW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // cdt_timer

//--- logic/cdt_top.v
// Three countdown timers with register window and interrupt outputs
// Assumes a word-addressed CPU bus port, read data one cycle after strobe
`timescale 1ns/100ps
`include "cdt_map.vh"
// What this block does
// - Three 32-bit timers with 16-bit prescalers
// - Count down, interrupt request at zero
// - Decrement once per prescaled tick
// - Auto reload from period at zero
// - Timer two drives line fourteen directly
// - Timer two picks one of four clocks
// - Timer one routable to line thirteen
// - Timer zero goes to interrupt expander
// - 64-word window at 0x0C00, no unlock
// - Window sits directly on CPU bus
// - Accepts 16-bit and 32-bit accesses
module cdt_top #(
  parameter AW = 22
) (
  clock,
  rst_b,
  bus_addr,
  bus_wdata,
  bus_wr,
  bus_rd,
  bus_wide,
  bus_rdata,
  internal_oscillator_one,
  internal_oscillator_two,
  ext_clock_src,
  interrupt_expander_req,
  cpu_irq_line_thirteen,
  cpu_irq_line_fourteen,
  irq
);
  input clock;
  input rst_b;
  input [AW-1:0] bus_addr;
  input [31:0] bus_wdata;
  input bus_wr;
  input bus_rd;
  input bus_wide;
  output [31:0] bus_rdata;
  input internal_oscillator_one;
  input internal_oscillator_two;
  input ext_clock_src;
  output interrupt_expander_req;
  output cpu_irq_line_thirteen;
  output cpu_irq_line_fourteen;
  output irq;
  wire clock;
  wire rst_b;
  wire [AW-1:0] bus_addr;
  wire [31:0] bus_wdata;
  wire bus_wr;
  wire bus_rd;
  wire bus_wide;
  wire internal_oscillator_one;
  wire internal_oscillator_two;
  wire ext_clock_src;
  // -----------------------------------------------------------------
  // Reset release
  // -----------------------------------------------------------------
  // Two edges of delay keep a late release from splitting the timers
  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_n;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;
  // -----------------------------------------------------------------
  // Address decode
  // -----------------------------------------------------------------
  // Straight decode on the CPU bus, no bridge, so no wait states
  wire in_win;
  wire [5:0] woff;
  wire [AW-1:0] win_base;
  assign win_base = `CDT_WIN_BASE;
  assign in_win = (bus_addr[AW-1:6] == win_base[AW-1:6]);
  assign woff = bus_addr[5:0];
  // Timer index of a word offset, 3 means shared area or the holes at 0x18 to 0x2F
  function [1:0] tmr_of;
    input [5:0] off;
    begin
      tmr_of = off[5:4] == 2'h3 ? 2'h3 : off[4:3];
      if (off[5]) begin
        tmr_of = 2'h3;
      end
    end
  endfunction
  // Wide access writes the addressed even word and the one above it
  wire [5:0] woff_hi;
  wire wide_ok;
  assign woff_hi = woff | 6'h01;
  assign wide_ok = bus_wide & ~woff[0];
  // Write strobe for a word offset: low half or high half of a wide write
  function wr_hit;
    input [5:0] off;
    input [5:0] lo;
    input [5:0] hi;
    input wide;
    begin
      wr_hit = (off == lo) | (wide & (off == hi));
    end
  endfunction
  function [15:0] wr_val;
    input [5:0] off;
    input [5:0] lo;
    input [31:0] wd;
    begin
      wr_val = (off == lo) ? wd[15:0] : wd[31:16];
    end
  endfunction
  // Window writes need no unlock step
  wire wr_en;
  assign wr_en = bus_wr & in_win;
  // -----------------------------------------------------------------
  // Timer registers and instances
  // -----------------------------------------------------------------
  reg [31:0] period_q [0:2];
  reg [15:0] prescale_q [0:2];
  reg [15:0] ctrl_q [0:2];
  reg [2:0] reload_q;
  wire [31:0] count_w [0:2];
  wire [2:0] zero_w;
  wire [2:0] tick_w;
  reg [1:0] clk_sel_q;
  // -----------------------------------------------------------------
  // Timer two clock source
  // -----------------------------------------------------------------
  cdt_tick_gen u_tick2 (
    .clock(clock),
    .rst_n(rst_n),
    .sel(clk_sel_q),
    .src_osc_one(internal_oscillator_one),
    .src_osc_two(internal_oscillator_two),
    .src_ext(ext_clock_src),
    .tick(tick_w[2])
  );
  // Timers zero and one count the CPU clock
  assign tick_w[1:0] = 2'h3;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_tmr
      wire [5:0] base;
      wire [5:0] a_plo;
      wire [5:0] a_phi;
      // Stride product cut to the offset width on purpose
      localparam integer base_int = gi * `CDT_TMR_STRIDE;
      assign base = base_int[5:0];
      assign a_plo = base | {3'h0, `CDT_OFF_PERIOD_LO};
      assign a_phi = base | {3'h0, `CDT_OFF_PERIOD_HI};
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          period_q[gi] <= `CDT_RST_PERIOD;
          prescale_q[gi] <= `CDT_RST_PRESCALE;
          ctrl_q[gi] <= `CDT_RST_CTRL;
          reload_q[gi] <= 1'b0;
        end else begin
          reload_q[gi] <= 1'b0;
          // Count words are read only, so writes there are dropped
          if (wr_en && tmr_of(woff) == gi) begin
            if (wr_hit(a_plo, woff, woff_hi, wide_ok)) begin
              period_q[gi][15:0] <= wr_val(a_plo, woff, bus_wdata);
            end
            if (wr_hit(a_phi, woff, woff_hi, wide_ok)) begin
              period_q[gi][31:16] <= wr_val(a_phi, woff, bus_wdata);
            end
            if (woff == (base | {3'h0, `CDT_OFF_CTRL})) begin
              ctrl_q[gi] <= bus_wdata[15:0] & 16'h0050;
              reload_q[gi] <= bus_wdata[`CDT_CTRL_RELOAD];
            end
            if (woff == (base | {3'h0, `CDT_OFF_PRESCALE})) begin
              prescale_q[gi] <= bus_wdata[15:0];
            end
          end
        end
      end
      cdt_timer #(
        .CW(32),
        .PW(16)
      ) u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .tick(tick_w[gi]),
        .stop(ctrl_q[gi][`CDT_CTRL_STOP]),
        .reload_req(reload_q[gi]),
        .period(period_q[gi]),
        .prescale(prescale_q[gi]),
        .count(count_w[gi]),
        .zero_evt(zero_w[gi])
      );
    end
  endgenerate
  // -----------------------------------------------------------------
  // Interrupt status and mask
  // -----------------------------------------------------------------
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  wire [2:0] stat_clr;
  assign stat_clr = (wr_en && woff == `CDT_OFF_IRQ_STATUS) ? bus_wdata[2:0] : 3'h0;
  // A wide write at the status word carries the mask in its upper half
  wire [15:0] mask_wv;
  assign mask_wv = wr_val(`CDT_OFF_IRQ_MASK, woff, bus_wdata);
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= `CDT_RST_MASK;
      clk_sel_q <= `CDT_CLK_SYSTEM;
    end else begin
      // Status sets whatever the mask, so masked timers can be polled
      // Set wins over a clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~stat_clr) | zero_w;
      if (wr_en && wr_hit(`CDT_OFF_IRQ_MASK, woff, woff_hi, wide_ok)) begin
        irq_mask_q <= mask_wv[2:0];
      end
      if (wr_en && woff == `CDT_OFF_CLK_SEL) begin
        clk_sel_q <= bus_wdata[1:0];
      end
    end
  end
  // -----------------------------------------------------------------
  // Interrupt outputs
  // -----------------------------------------------------------------
  wire [2:0] irq_act;
  assign irq_act = irq_stat_q & irq_mask_q;
  assign interrupt_expander_req = irq_act[0];
  // Line thirteen only when software routes timer one there
  assign cpu_irq_line_thirteen = irq_act[1] & ctrl_q[1][`CDT_CTRL_ROUTE13];
  assign cpu_irq_line_fourteen = irq_act[2];
  assign irq = |irq_act;
  // -----------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------
  // Wide reads pair the even word with the one above it
  function [15:0] rd_word;
    input [5:0] off;
    input [31:0] c0;
    input [31:0] c1;
    input [31:0] c2;
    input [31:0] p0;
    input [31:0] p1;
    input [31:0] p2;
    input [47:0] cp;
    input [47:0] ps;
    input [8:0] sh;
    reg [31:0] c;
    reg [31:0] p;
    begin
      c = off[4:3] == 2'h0 ? c0 : off[4:3] == 2'h1 ? c1 : c2;
      p = off[4:3] == 2'h0 ? p0 : off[4:3] == 2'h1 ? p1 : p2;
      // Holes at offsets 0x18 to 0x2F read as zero
      rd_word = 16'h0000;
      if (off[5]) begin
        case (off)
          `CDT_OFF_IRQ_STATUS: rd_word = {13'h0000, sh[2:0]};
          `CDT_OFF_IRQ_MASK: rd_word = {13'h0000, sh[5:3]};
          `CDT_OFF_CLK_SEL: rd_word = {14'h0000, sh[7:6]};
          default: rd_word = 16'h0000;
        endcase
      end else if (off[4:3] != 2'h3) begin
        case (off[2:0])
          `CDT_OFF_COUNT_LO: rd_word = c[15:0];
          `CDT_OFF_COUNT_HI: rd_word = c[31:16];
          `CDT_OFF_PERIOD_LO: rd_word = p[15:0];
          `CDT_OFF_PERIOD_HI: rd_word = p[31:16];
          `CDT_OFF_CTRL: rd_word = cp[off[4:3]*16 +: 16];
          `CDT_OFF_PRESCALE: rd_word = ps[off[4:3]*16 +: 16];
          default: rd_word = 16'h0000;
        endcase
      end
    end
  endfunction
  wire [47:0] ctrl_all;
  wire [47:0] psc_all;
  wire [8:0] shared_all;
  wire [15:0] rd_lo;
  wire [15:0] rd_hi;
  assign ctrl_all = {ctrl_q[2], ctrl_q[1], ctrl_q[0]};
  assign psc_all = {prescale_q[2], prescale_q[1], prescale_q[0]};
  assign shared_all = {1'b0, clk_sel_q, irq_mask_q, irq_stat_q};
  assign rd_lo = rd_word(woff, count_w[0], count_w[1], count_w[2], period_q[0],
                         period_q[1], period_q[2], ctrl_all, psc_all, shared_all);
  assign rd_hi = rd_word(woff_hi, count_w[0], count_w[1], count_w[2], period_q[0],
                         period_q[1], period_q[2], ctrl_all, psc_all, shared_all);
  // Back to zero after one cycle, so no stale word lingers on the bus
  reg [31:0] rdata_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_rd && in_win) begin
      rdata_q <= {wide_ok ? rd_hi : 16'h0000, rd_lo};
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign bus_rdata = rdata_q;
endmodule // cdt_top

//--- sim/cdt_top_sva.sv
// Checker for the countdown timer block
// Assumes it is bound onto cdt_top and sees its ports only
`timescale 1ns/100ps
module cdt_top_sva #(
  parameter AW = 22
) (
  input wire clock,
  input wire rst_b,
  input wire [AW-1:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire bus_wide,
  input wire [31:0] bus_rdata,
  input wire interrupt_expander_req,
  input wire cpu_irq_line_thirteen,
  input wire cpu_irq_line_fourteen,
  input wire irq
);
  // ----
  // Properties
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Upper address bits of the 64-word window
  wire in_win = bus_addr[AW-1:6] == 16'h0030;
  wire mask_zero = bus_wr && bus_addr == 22'h00_0C31 && bus_wdata[2:0] == 3'h0;
  chk_exp_in_irq: assert property (interrupt_expander_req |-> irq)
    else $error("expander request without irq");
  chk_l13_in_irq: assert property (cpu_irq_line_thirteen |-> irq)
    else $error("line thirteen without irq");
  chk_l14_in_irq: assert property (cpu_irq_line_fourteen |-> irq)
    else $error("line fourteen without irq");
  chk_rd_idle: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
  chk_rd_outside: assert property ($past(bus_rd && !in_win) |-> bus_rdata == 32'h0000_0000)
    else $error("read outside window not zero");
  chk_narrow_read: assert property ($past(bus_rd && (!bus_wide || bus_addr[0]))
    |-> bus_rdata[31:16] == 16'h0000)
    else $error("narrow read upper half not zero");
  chk_mask_off: assert property ($past(mask_zero) |-> !irq)
    else $error("irq with all masked");
  chk_exp_holds: assert property (interrupt_expander_req && !bus_wr
    |=> interrupt_expander_req)
    else $error("expander request dropped");
  chk_l14_holds: assert property (cpu_irq_line_fourteen && !bus_wr
    |=> cpu_irq_line_fourteen)
    else $error("line fourteen dropped");
  chk_l13_holds: assert property (cpu_irq_line_thirteen && !bus_wr
    |=> cpu_irq_line_thirteen)
    else $error("line thirteen dropped");
  cover property (cpu_irq_line_thirteen);
  cover property (cpu_irq_line_fourteen);
  cover property ($past(bus_rd && bus_wide));
endmodule // cdt_top_sva

bind cdt_top cdt_top_sva #(.AW(AW)) u_sva (
  .clock(clock),
  .rst_b(rst_b),
  .bus_addr(bus_addr),
  .bus_wdata(bus_wdata),
  .bus_wr(bus_wr),
  .bus_rd(bus_rd),
  .bus_wide(bus_wide),
  .bus_rdata(bus_rdata),
  .interrupt_expander_req(interrupt_expander_req),
  .cpu_irq_line_thirteen(cpu_irq_line_thirteen),
  .cpu_irq_line_fourteen(cpu_irq_line_fourteen),
  .irq(irq)
);

//--- sim/cdt_cpu_model.sv
// CPU side model: counts rising edges of the three interrupt lines
// Assumes level lines in the clock domain
`timescale 1ns/100ps
module cdt_cpu_model (
  input wire clock,
  input wire rst_b,
  input wire exp_req,
  input wire line13,
  input wire line14,
  output reg [7:0] n_exp,
  output reg [7:0] n_13,
  output reg [7:0] n_14
);
  reg [2:0] last_q;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      last_q <= 3'h0;
      n_exp <= 8'h00;
      n_13 <= 8'h00;
      n_14 <= 8'h00;
    end else begin
      last_q <= {line14, line13, exp_req};
      n_exp <= n_exp + {7'h00, exp_req & ~last_q[0]};
      n_13 <= n_13 + {7'h00, line13 & ~last_q[1]};
      n_14 <= n_14 + {7'h00, line14 & ~last_q[2]};
    end
  end
endmodule // cdt_cpu_model

//--- sim/tb_cdt_top.sv
// Bench for the countdown timers: bus tasks, one task per scenario
// Assumes the design, its checker and the CPU model are compiled first
`timescale 1ns/100ps
module tb_cdt_top;
  reg clock = 1'b0;
  reg rst_b = 1'b0;
  reg [21:0] bus_addr = 22'h00_0000;
  reg [31:0] bus_wdata = 32'h0000_0000;
  reg bus_wr = 1'b0;
  reg bus_rd = 1'b0;
  reg bus_wide = 1'b0;
  reg [2:0] src = 3'h0;
  wire [31:0] bus_rdata;
  wire [2:0] ln;
  wire irq;
  wire [7:0] n_exp;
  wire [7:0] n_13;
  wire [7:0] n_14;
  integer num_errors = 0;
  integer n_checks = 0;
  integer cyc = 0;
  always #5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  cdt_top uut (
    .clock(clock),
    .rst_b(rst_b),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_wide(bus_wide),
    .bus_rdata(bus_rdata),
    .internal_oscillator_one(src[0]),
    .internal_oscillator_two(src[1]),
    .ext_clock_src(src[2]),
    .interrupt_expander_req(ln[0]),
    .cpu_irq_line_thirteen(ln[1]),
    .cpu_irq_line_fourteen(ln[2]),
    .irq(irq)
  );
  cdt_cpu_model cpu (
    .clock(clock),
    .rst_b(rst_b),
    .exp_req(ln[0]),
    .line13(ln[1]),
    .line14(ln[2]),
    .n_exp(n_exp),
    .n_13(n_13),
    .n_14(n_14)
  );
  // ----
  // Helpers
  // ----
  task report_and_stop;
    begin
      if (num_errors == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task ck(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("wrong value %s: expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Settle 1 ns past the edge so outputs are stable
  task wt(input integer n);
    begin
      repeat (n) @(posedge clock);
      #1;
    end
  endtask
  task acc(input r, input [6:0] o, input [31:0] d, input w, output [31:0] q);
    begin
      @(posedge clock);
      bus_addr <= 22'h00_0C00 + {15'h0000, o};
      bus_wdata <= d;
      bus_wide <= w;
      bus_rd <= r;
      bus_wr <= ~r;
      @(posedge clock);
      bus_rd <= 1'b0;
      bus_wr <= 1'b0;
      #1 q = bus_rdata;
    end
  endtask
  task wr(input [6:0] o, input [31:0] d, input w);
    reg [31:0] q;
    begin
      acc(1'b0, o, d, w, q);
    end
  endtask
  task rc(input string nm, input [6:0] o, input w, input [31:0] e);
    reg [31:0] q;
    begin
      acc(1'b1, o, 32'h0000_0000, w, q);
      ck(nm, e, q);
    end
  endtask
  // Bounded wait for one interrupt line
  task wl(input integer k, output integer c);
    integer i;
    begin
      c = -1;
      for (i = 0; i < 200 && c < 0; i = i + 1) begin
        wt(1);
        if (ln[k] === 1'b1) c = cyc;
      end
    end
  endtask
  task pl(input [2:0] m);
    begin
      @(posedge clock);
      src <= m;
      repeat (4) @(posedge clock);
      src <= 3'h0;
      wt(4);
    end
  endtask
  // ----
  // Scenarios
  // ----
  task t_reset;
    begin
      rc("period0", 7'h02, 1'b1, 32'hFFFF_FFFF);
      rc("prescale0", 7'h06, 1'b0, 32'h0000_0000);
      rc("status", 7'h30, 1'b0, 32'h0000_0000);
      rc("mask", 7'h31, 1'b0, 32'h0000_0000);
      rc("clk_sel", 7'h32, 1'b0, 32'h0000_0000);
    end
  endtask
  task t_width;
    begin
      wr(7'h0A, 32'h1234_5678, 1'b1);
      rc("per lo", 7'h0A, 1'b0, 32'h0000_5678);
      rc("per hi", 7'h0B, 1'b0, 32'h0000_1234);
      wr(7'h0B, 32'hAAAA_0042, 1'b0);
      rc("per wide", 7'h0A, 1'b1, 32'h0042_5678);
      rc("odd wide", 7'h0B, 1'b1, 32'h0000_0042);
      wr(7'h30, 32'h0005_0000, 1'b1);
      rc("mask wide", 7'h30, 1'b1, 32'h0005_0000);
      wr(7'h31, 32'h0000_0000, 1'b0);
      rc("mask narrow", 7'h31, 1'b0, 32'h0000_0000);
      rc("unmapped", 7'h3F, 1'b0, 32'h0000_0000);
      rc("outside", 7'h40, 1'b1, 32'h0000_0000);
    end
  endtask
  task t_count;
    reg [31:0] a;
    reg [31:0] b;
    integer p;
    begin
      wr(7'h02, 32'h0001_0005, 1'b1);
      wr(7'h04, 32'h0000_0030, 1'b0);
      rc("loaded", 7'h00, 1'b1, 32'h0001_0005);
      wt(5);
      rc("frozen", 7'h00, 1'b1, 32'h0001_0005);
      for (p = 0; p < 2; p = p + 1) begin
        wr(7'h06, p, 1'b0);
        wr(7'h04, 32'h0000_0020, 1'b0);
        acc(1'b1, 7'h00, 32'h0000_0000, 1'b1, a);
        wt(19);
        acc(1'b1, 7'h00, 32'h0000_0000, 1'b1, b);
        ck("steps", 21 / (p + 1), a - b);
      end
      wr(7'h04, 32'h0000_0010, 1'b0);
    end
  endtask
  task t_period;
    integer c0;
    integer c1;
    begin
      wr(7'h0A, 32'h0000_0003, 1'b1);
      wr(7'h0E, 32'h0000_0001, 1'b0);
      wr(7'h31, 32'h0000_0002, 1'b0);
      wr(7'h0C, 32'h0000_0060, 1'b0);
      wr(7'h30, 32'h0000_0007, 1'b0);
      wl(1, c0);
      wr(7'h30, 32'h0000_0002, 1'b0);
      wl(1, c1);
      ck("period", 8, c1 - c0);
      ck("l13 count", 1, n_13);
      wr(7'h0C, 32'h0000_0000, 1'b0);
      wt(10);
      ck("l13 off", 0, ln[1]);
      ck("irq", 1, irq);
      wr(7'h31, 32'h0000_0000, 1'b0);
      ck("irq masked", 0, irq);
      rc("status set", 7'h30, 1'b0, 32'h0000_0002);
      wr(7'h0C, 32'h0000_0010, 1'b0);
      wr(7'h30, 32'h0000_0007, 1'b0);
    end
  endtask
  task t_exp;
    begin
      wr(7'h02, 32'h0000_0004, 1'b1);
      wr(7'h31, 32'h0000_0001, 1'b0);
      wr(7'h04, 32'h0000_0020, 1'b0);
      wt(12);
      ck("exp count", 1, n_exp);
      ck("l13 quiet", 0, ln[1]);
      wr(7'h04, 32'h0000_0010, 1'b0);
      wr(7'h31, 32'h0000_0000, 1'b0);
      wr(7'h30, 32'h0000_0007, 1'b0);
    end
  endtask
  // Unselected sources toggle too, to show they are ignored
  task t_src;
    integer s;
    begin
      wr(7'h12, 32'h0000_0002, 1'b1);
      wr(7'h31, 32'h0000_0004, 1'b0);
      for (s = 0; s < 3; s = s + 1) begin
        wr(7'h32, s + 1, 1'b0);
        wr(7'h14, 32'h0000_0020, 1'b0);
        wr(7'h30, 32'h0000_0004, 1'b0);
        pl(3'h7);
        pl(3'h7);
        pl(3'h7 ^ (3'h1 << s));
        ck("l14 early", 0, ln[2]);
        pl(3'h1 << s);
        ck("l14", 1, ln[2]);
      end
      ck("l14 count", 3, n_14);
    end
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    wt(3);
    t_reset;
    t_width;
    t_count;
    t_period;
    t_exp;
    t_src;
    report_and_stop;
  end
  // Whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge clock);
    num_errors = num_errors + 1;
    report_and_stop;
  end
endmodule // tb_cdt_top
